// ==== logic/assc_channel.sv ====
// Asynchronous/synchronous serial channel with AHB-Lite registers.
// Assumes one 50 MHz clock; the receive pin is synchronised inside.
//
// What this block does
// - Asynchronous transmit and receive run at the same time, full duplex.
// - Synchronous mode moves data one way at a time, up to a quarter tick rate.
// - An asynchronous frame is a start bit, 8 or 9 data bits, one or two stops.
// - Wake-up mode sends 8 data bits plus a ninth bit marking address bytes.
// - Synchronous mode moves 8-bit bytes on a shift clock this channel drives.
// - The least significant bit is always shifted first.
// - Loopback routes the transmitter output straight into the receiver.
// - With parity, a parity bit is sent and each received one is checked.
// - With framing checks on, a missing stop bit raises a framing error.
// - A character completing while the last one is unread raises overrun.
// - Four request lines cover transmit, buffer empty, receive and error.
// - A programmable divider derives every bit rate from the core clock.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module assc_channel (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // Serial pins
    input  wire logic        rxd_i,
    output logic             rxd_o,
    output logic             rxd_oe_o,
    output logic             txd_o,
    // Interrupts
    output logic [3:0]       irq_req_o,
    output logic             irq_o
);

    assc_pkg::assc_core_s r_reg;
    assc_pkg::assc_core_s r_next;
    assc_pkg::assc_stat_s ev;
    assc_pkg::assc_stat_s w1c;
    logic                 tick;
    logic                 acc;
    logic                 rd_rx;
    logic                 lin;
    logic                 nine;
    logic                 par;
    logic                 wake;
    logic                 sy;
    logic                 rx_done;
    logic [8:0]           word;

    assc_baud u_baud (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .en_i       (r_reg.ctrl.run),
        .reload_i   (r_reg.reload),
        .tick_o     (tick)
    );

    always_comb begin
        r_next  = r_reg;
        ev      = '0;
        w1c     = '0;
        rx_done = 1'b0;
        word    = '0;
        nine    = 1'b0;
        par     = 1'b0;
        wake    = 1'b0;
        sy      = 1'b0;
        acc     = hsel_i & hready_i & htrans_i[1] & (hsize_i == assc_pkg::HSIZE_WORD);
        rd_rx   = acc & !hwrite_i & (haddr_i[assc_pkg::AW-1:0] == assc_pkg::A_RXDATA);
        unique case (r_reg.ctrl.mode)
            assc_pkg::M_SYNC: sy = 1'b1;
            assc_pkg::M_A8P: begin
                nine = 1'b1;
                par  = 1'b1;
            end
            assc_pkg::M_A9: nine = 1'b1;
            assc_pkg::M_A8W: begin
                nine = 1'b1;
                wake = 1'b1;
            end
            default: nine = 1'b0;
        endcase
        // Only the second stage feeds logic; the first may be metastable.
        r_next.rx_s1   = rxd_i;
        r_next.rx_s2   = r_reg.rx_s1;
        lin            = r_reg.ctrl.loop ? r_reg.tx_line : r_reg.rx_s2;
        r_next.rx_prev = lin;

        // Transmitter; in synchronous mode it also clocks reception.
        unique case (r_reg.tx_st)
            assc_pkg::TX_IDLE: begin
                r_next.tx_sub = '0;
                r_next.tx_bit = '0;
                if (r_reg.tfull) begin
                    r_next.tx_sh = r_reg.tbuf;
                    if (par) begin
                        r_next.tx_sh[8] = ^r_reg.tbuf[7:0] ^ r_reg.ctrl.odd;
                    end
                    r_next.tfull  = 1'b0;
                    ev.tbe        = 1'b1;
                    r_next.tx_dir = 1'b1;
                    r_next.dat_oe = sy;
                    r_next.sclk   = !sy;
                    r_next.tx_st  = sy ? assc_pkg::TX_DATA : assc_pkg::TX_START;
                end else if (sy && r_reg.ctrl.ren) begin
                    r_next.tx_dir = 1'b0;
                    r_next.sclk   = 1'b0;
                    r_next.tx_st  = assc_pkg::TX_DATA;
                end
            end
            assc_pkg::TX_START: begin
                if (tick) begin
                    r_next.tx_sub = r_reg.tx_sub + 1'b1;
                    if (r_reg.tx_sub == assc_pkg::OVS_LAST) begin
                        r_next.tx_st = assc_pkg::TX_DATA;
                    end
                end
            end
            assc_pkg::TX_DATA: begin
                if (tick && sy) begin
                    r_next.tx_sub = r_reg.tx_sub + 1'b1;
                    // Data is sampled on the rising shift clock edge.
                    if (r_reg.tx_sub == assc_pkg::SY_RISE) begin
                        r_next.sclk = 1'b1;
                        if (!r_reg.tx_dir) begin
                            r_next.rx_sh = {lin, r_reg.rx_sh[8:1]};
                        end
                    end
                    if (r_reg.tx_sub == assc_pkg::SY_LAST) begin
                        r_next.sclk   = 1'b0;
                        r_next.tx_sub = '0;
                        r_next.tx_sh  = {1'b0, r_reg.tx_sh[8:1]};
                        r_next.tx_bit = r_reg.tx_bit + 1'b1;
                        if (r_reg.tx_bit == assc_pkg::LAST_DBIT) begin
                            r_next.tx_st  = assc_pkg::TX_IDLE;
                            r_next.sclk   = 1'b1;
                            r_next.dat_oe = 1'b0;
                            if (r_reg.tx_dir) begin
                                ev.tx = 1'b1;
                            end else begin
                                rx_done         = 1'b1;
                                word            = {1'b0, r_reg.rx_sh[8:1]};
                                r_next.ctrl.ren = 1'b0;
                            end
                        end
                    end
                end else if (tick) begin
                    r_next.tx_sub = r_reg.tx_sub + 1'b1;
                    if (r_reg.tx_sub == assc_pkg::OVS_LAST) begin
                        r_next.tx_sh  = {1'b0, r_reg.tx_sh[8:1]};
                        r_next.tx_bit = r_reg.tx_bit + 1'b1;
                        if (r_reg.tx_bit == assc_pkg::LAST_DBIT) begin
                            r_next.tx_bit = '0;
                            r_next.tx_st  = nine ? assc_pkg::TX_NINTH : assc_pkg::TX_STOP;
                        end
                    end
                end
            end
            assc_pkg::TX_NINTH: begin
                if (tick) begin
                    r_next.tx_sub = r_reg.tx_sub + 1'b1;
                    if (r_reg.tx_sub == assc_pkg::OVS_LAST) begin
                        r_next.tx_st = assc_pkg::TX_STOP;
                    end
                end
            end
            assc_pkg::TX_STOP: begin
                if (tick) begin
                    r_next.tx_sub = r_reg.tx_sub + 1'b1;
                    if (r_reg.tx_sub == assc_pkg::OVS_LAST) begin
                        if (r_reg.ctrl.stop2 && r_reg.tx_bit == '0) begin
                            r_next.tx_bit = 4'h1;
                        end else begin
                            r_next.tx_st = assc_pkg::TX_IDLE;
                            ev.tx        = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Asynchronous receiver, independent of the transmitter.
        unique case (r_reg.rx_st)
            assc_pkg::RX_IDLE: begin
                r_next.rx_sub = '0;
                r_next.rx_bit = '0;
                if (!sy && r_reg.ctrl.ren && r_reg.rx_prev && !lin) begin
                    r_next.rx_st = assc_pkg::RX_START;
                end
            end
            assc_pkg::RX_START: begin
                if (tick) begin
                    r_next.rx_sub = r_reg.rx_sub + 1'b1;
                    // A glitch shorter than half a bit is not a start bit.
                    if (r_reg.rx_sub == assc_pkg::OVS_MID && lin) begin
                        r_next.rx_st = assc_pkg::RX_IDLE;
                    end
                    if (r_reg.rx_sub == assc_pkg::OVS_LAST) begin
                        r_next.rx_st = assc_pkg::RX_DATA;
                    end
                end
            end
            assc_pkg::RX_DATA: begin
                if (tick) begin
                    r_next.rx_sub = r_reg.rx_sub + 1'b1;
                    if (r_reg.rx_sub == assc_pkg::OVS_MID) begin
                        r_next.rx_sh = {lin, r_reg.rx_sh[8:1]};
                    end
                    if (r_reg.rx_sub == assc_pkg::OVS_LAST) begin
                        r_next.rx_bit = r_reg.rx_bit + 1'b1;
                        if (r_reg.rx_bit == assc_pkg::LAST_DBIT) begin
                            r_next.rx_st = nine ? assc_pkg::RX_NINTH : assc_pkg::RX_STOP;
                        end
                    end
                end
            end
            assc_pkg::RX_NINTH: begin
                if (tick) begin
                    r_next.rx_sub = r_reg.rx_sub + 1'b1;
                    if (r_reg.rx_sub == assc_pkg::OVS_MID) begin
                        r_next.rx_sh = {lin, r_reg.rx_sh[8:1]};
                    end
                    if (r_reg.rx_sub == assc_pkg::OVS_LAST) begin
                        r_next.rx_st = assc_pkg::RX_STOP;
                    end
                end
            end
            assc_pkg::RX_STOP: begin
                // The frame ends mid stop bit so a back-to-back start is seen.
                if (tick) begin
                    r_next.rx_sub = r_reg.rx_sub + 1'b1;
                    if (r_reg.rx_sub == assc_pkg::OVS_MID) begin
                        r_next.rx_st = assc_pkg::RX_IDLE;
                        rx_done      = 1'b1;
                        word         = nine ? r_reg.rx_sh : {1'b0, r_reg.rx_sh[8:1]};
                        if (r_reg.ctrl.fen && !lin) begin
                            ev.fe = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Register bus: writes land in the data phase, reads are staged.
        r_next.hrdata  = '0;
        r_next.dp_wr   = acc & hwrite_i;
        r_next.dp_addr = haddr_i[assc_pkg::AW-1:0];
        if (r_reg.dp_wr) begin
            case (r_reg.dp_addr)
                assc_pkg::A_CTRL:
                    r_next.ctrl = assc_pkg::assc_ctrl_s'(hwdata_i[assc_pkg::CTRL_W-1:0]);
                assc_pkg::A_BAUD: r_next.reload = hwdata_i[assc_pkg::BRW-1:0];
                assc_pkg::A_TXDATA: begin
                    r_next.tbuf  = hwdata_i[8:0];
                    r_next.tfull = 1'b1;
                end
                assc_pkg::A_STAT: w1c = hwdata_i[assc_pkg::STAT_W-1:0];
                assc_pkg::A_MASK: r_next.mask = hwdata_i[assc_pkg::STAT_W-1:0];
                default: r_next.dp_wr = r_next.dp_wr;
            endcase
        end
        if (acc && !hwrite_i) begin
            case (haddr_i[assc_pkg::AW-1:0])
                assc_pkg::A_CTRL:   r_next.hrdata = 32'(r_reg.ctrl);
                assc_pkg::A_BAUD:   r_next.hrdata = 32'(r_reg.reload);
                assc_pkg::A_TXDATA: r_next.hrdata = 32'(r_reg.tbuf);
                assc_pkg::A_RXDATA: r_next.hrdata = 32'(r_reg.rbuf);
                assc_pkg::A_STAT: begin
                    r_next.hrdata = 32'({r_reg.tx_st != assc_pkg::TX_IDLE,
                                         r_reg.rfull, r_reg.tfull, r_reg.stat});
                end
                assc_pkg::A_MASK:   r_next.hrdata = 32'(r_reg.mask);
                default:            r_next.hrdata = '0;
            endcase
        end
        if (rd_rx) begin
            r_next.rfull = 1'b0;
        end

        // A completed character beats a read in the same cycle.
        if (rx_done) begin
            if (par && (^word != r_reg.ctrl.odd)) begin
                ev.pe = 1'b1;
            end
            if (!wake || word[8]) begin
                if (r_next.rfull) begin
                    ev.oe = 1'b1;
                end
                r_next.rbuf  = word;
                r_next.rfull = 1'b1;
                ev.rx        = 1'b1;
            end
        end
        ev.err = ev.pe | ev.fe | ev.oe;

        if (sy) begin
            r_next.rx_st = assc_pkg::RX_IDLE;
        end
        if (!r_reg.ctrl.run) begin
            r_next.tx_st  = assc_pkg::TX_IDLE;
            r_next.rx_st  = assc_pkg::RX_IDLE;
            r_next.sclk   = 1'b1;
            r_next.dat_oe = 1'b0;
        end
        unique case (r_next.tx_st)
            assc_pkg::TX_START: r_next.tx_line = 1'b0;
            assc_pkg::TX_DATA:  r_next.tx_line = r_next.tx_sh[0];
            assc_pkg::TX_NINTH: r_next.tx_line = r_next.tx_sh[0];
            default:            r_next.tx_line = 1'b1;
        endcase
        r_next.txd  = sy ? r_next.sclk : r_next.tx_line;
        r_next.stat = (r_reg.stat & ~w1c) | ev;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            r_reg <= assc_pkg::CORE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = r_reg.hrdata;
    assign txd_o       = r_reg.txd;
    assign rxd_o       = r_reg.tx_line;
    assign rxd_oe_o    = r_reg.dat_oe;
    assign irq_req_o   = r_reg.stat[3:0] & r_reg.mask[3:0];
    assign irq_o       = |(r_reg.stat & r_reg.mask);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_tx_load;
        r_reg.ctrl.run && r_reg.tx_st == assc_pkg::TX_IDLE && r_reg.tfull;
    endsequence

    sequence s_tx_busy;
        r_reg.stat.tbe && r_reg.tx_st != assc_pkg::TX_IDLE;
    endsequence

    sequence s_rx_edge;
        r_reg.ctrl.run && !sy && r_reg.ctrl.ren && r_reg.rx_st == assc_pkg::RX_IDLE
            && r_reg.rx_prev && !lin;
    endsequence

    chk_duplex_rx: assert property (
        (r_reg.tx_st != assc_pkg::TX_IDLE) and s_rx_edge
            |=> r_reg.rx_st == assc_pkg::RX_START)
        else $error("receiver did not start while transmitter busy");

    chk_start_low: assert property (
        (r_reg.tx_st == assc_pkg::TX_START && !sy) |-> !txd_o)
        else $error("start bit not low");

    chk_stop_high: assert property (
        (r_reg.tx_st == assc_pkg::TX_STOP && !sy) |-> txd_o)
        else $error("stop bit not high");

    chk_sync_rise: assert property (
        (sy && tick && r_reg.tx_st == assc_pkg::TX_DATA && r_reg.tx_sub == assc_pkg::SY_RISE)
            |=> txd_o ##1 txd_o)
        else $error("shift clock high phase wrong");

    chk_lsb_first: assert property (
        $rose(r_reg.tx_st == assc_pkg::TX_DATA) && !sy |-> txd_o == $past(r_reg.tx_sh[0], 1))
        else $error("first data bit is not the least significant");

    chk_loop_start: assert property (
        (r_reg.ctrl.loop && r_reg.rx_prev && $fell(r_reg.tx_line) && !sy && r_reg.ctrl.run
            && r_reg.ctrl.ren && r_reg.rx_st == assc_pkg::RX_IDLE)
            |=> r_reg.rx_st == assc_pkg::RX_START)
        else $error("loopback did not reach receiver");

    chk_parity_err: assert property (
        (rx_done && par && (^word != r_reg.ctrl.odd)) |=> r_reg.stat.pe && r_reg.stat.err)
        else $error("parity mismatch not flagged");

    chk_frame_err: assert property (
        (tick && r_reg.rx_st == assc_pkg::RX_STOP && r_reg.rx_sub == assc_pkg::OVS_MID
            && r_reg.ctrl.fen && !lin) |=> r_reg.stat.fe)
        else $error("missing stop bit not flagged");

    chk_overrun_flag: assert property (
        (rx_done && r_reg.rfull && !rd_rx && (!wake || word[8])) |=> r_reg.stat.oe)
        else $error("overrun not flagged");

    chk_tbe_on_load: assert property (
        s_tx_load |=> s_tx_busy)
        else $error("buffer empty request missing at load");

endmodule // assc_channel

`default_nettype wire

// ==== logic/assc_pkg.sv ====
// Package of the serial channel: register map, field layouts, states and timing.
// Assumes a single 50 MHz core clock and a 32-bit AHB-Lite register bus.
`default_nettype none

package assc_pkg;

    // Register byte offsets within the block's window.
    localparam int         AW       = 5;
    localparam logic [4:0] A_CTRL   = 5'h00;
    localparam logic [4:0] A_BAUD   = 5'h04;
    localparam logic [4:0] A_TXDATA = 5'h08;
    localparam logic [4:0] A_RXDATA = 5'h0C;
    localparam logic [4:0] A_STAT   = 5'h10;
    localparam logic [4:0] A_MASK   = 5'h14;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Baud reload width; one tick every reload+1 clocks.
    localparam int                BRW      = 13;
    localparam logic [BRW-1:0]    BAUD_RST = 13'h0000;

    // Ticks: 16 per asynchronous bit, 4 per synchronous bit.
    localparam logic [3:0] OVS_LAST  = 4'hF;
    localparam logic [3:0] OVS_MID   = 4'h7;
    localparam logic [3:0] SY_RISE   = 4'h1;
    localparam logic [3:0] SY_LAST   = 4'h3;
    localparam logic [3:0] LAST_DBIT = 4'h7;

    typedef enum logic [2:0] {
        M_SYNC = 3'h0,
        M_A8   = 3'h1,
        M_A8P  = 3'h3,
        M_A9   = 3'h4,
        M_A8W  = 3'h5
    } assc_mode_e;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h3,
        TX_NINTH = 3'h2,
        TX_STOP  = 3'h6
    } assc_tx_e;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h3,
        RX_NINTH = 3'h2,
        RX_STOP  = 3'h6
    } assc_rx_e;

    typedef struct packed {
        logic       run;
        logic       ren;
        logic       loop;
        logic       fen;
        logic       odd;
        logic       stop2;
        assc_mode_e mode;
    } assc_ctrl_s;

    localparam int         CTRL_W   = $bits(assc_ctrl_s);
    localparam assc_ctrl_s CTRL_RST = '{mode: M_SYNC, default: 1'b0};

    // Sticky events; the low four bits are the four request lines.
    typedef struct packed {
        logic oe;
        logic fe;
        logic pe;
        logic err;
        logic rx;
        logic tbe;
        logic tx;
    } assc_stat_s;

    localparam int STAT_W = $bits(assc_stat_s);

    typedef struct packed {
        logic [BRW-1:0] cnt;
        logic           tick;
    } assc_baud_s;

    typedef struct packed {
        assc_ctrl_s     ctrl;
        logic [BRW-1:0] reload;
        assc_stat_s     stat;
        assc_stat_s     mask;
        logic [8:0]     tbuf;
        logic           tfull;
        assc_tx_e       tx_st;
        logic [3:0]     tx_sub;
        logic [3:0]     tx_bit;
        logic [8:0]     tx_sh;
        logic           tx_line;
        logic           tx_dir;
        logic           sclk;
        logic           dat_oe;
        logic           txd;
        logic           rx_s1;
        logic           rx_s2;
        logic           rx_prev;
        assc_rx_e       rx_st;
        logic [3:0]     rx_sub;
        logic [3:0]     rx_bit;
        logic [8:0]     rx_sh;
        logic [8:0]     rbuf;
        logic           rfull;
        logic           dp_wr;
        logic [AW-1:0]  dp_addr;
        logic [31:0]    hrdata;
    } assc_core_s;

    localparam assc_core_s CORE_RST = '{
        ctrl:    CTRL_RST,
        reload:  BAUD_RST,
        tx_st:   TX_IDLE,
        rx_st:   RX_IDLE,
        tx_line: 1'b1,
        sclk:    1'b1,
        txd:     1'b1,
        rx_s1:   1'b1,
        rx_s2:   1'b1,
        rx_prev: 1'b1,
        default: '0
    };

endpackage

`default_nettype wire

// ==== logic/assc_baud.sv ====
// Baud tick generator of the serial channel.
// Assumes the enable and reload come from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none

module assc_baud (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  nrst_i,
    // Control
    input  wire logic                  en_i,
    input  wire logic [assc_pkg::BRW-1:0] reload_i,
    // Tick
    output logic                       tick_o
);

    assc_pkg::assc_baud_s s_reg;
    assc_pkg::assc_baud_s s_next;

    // Every bit rate is a whole division of the core clock.
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (!en_i) begin
            s_next.cnt = reload_i;
        end else if (s_reg.cnt == '0) begin
            s_next.cnt  = reload_i;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;

    chk_baud_gap: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_reg.tick && s_reg.cnt != '0) |=> !s_reg.tick)
        else $error("baud tick repeated before reload ran out");

endmodule // assc_baud

`default_nettype wire

// ==== verification/assc_remote.sv ====
// Remote serial party: sends frames on the receive pin and decodes transmit frames.
// Assumes baud reload 0, so one asynchronous bit lasts 16 clocks.
`timescale 1ns/10ps
`default_nettype none

module assc_remote (
    input  wire logic  clk_i,
    input  wire logic  line_i,
    output logic       line_o,
    output logic [7:0] got_o,
    output logic       got_v_o
);
    initial line_o = 1'b1;
    initial got_v_o = 1'b0;

    task automatic send(input logic [8:0] v, input int n, input logic stp);
        line_o <= 1'b0;
        repeat (16) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= v[i];
            repeat (16) @(posedge clk_i);
        end
        line_o <= stp;
        repeat (16) @(posedge clk_i);
        line_o <= 1'b1;
        // One idle clock keeps back-to-back frames from assigning the line twice.
        @(posedge clk_i);
    endtask

    // Samples mid-bit; a low stop bit yields no pulse, so the bench wait runs out.
    always begin
        @(negedge line_i);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            got_o[i] = line_i;
        end
        repeat (16) @(posedge clk_i);
        got_v_o = line_i;
        @(posedge clk_i);
        got_v_o = 1'b0;
    end
endmodule // assc_remote

`default_nettype wire

// ==== verification/test_async_sync_serial_channel.sv ====
// Self-checking bench of the serial channel: AHB-Lite master, remote party, watchdog.
// Assumes baud reload 0 and the register map of the channel package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end

module test_async_sync_serial_channel;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        dph = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready, hresp, rxd_o, rxd_oe, txd, irq, rline, got_v;
    logic [3:0]  irq_req;
    logic [7:0]  got, b, sb;
    logic [31:0] qe[$], qm[$];
    logic [7:0]  qt[$];
    int          err_count = 0;
    int          check_count = 0;

    initial begin
        forever #10 clk = ~clk;
    end

    assc_channel u_dut (.core_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .rxd_i(rxd_oe ? rxd_o : rline), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd),
        .irq_req_o(irq_req), .irq_o(irq));
    assc_remote u_rem (.clk_i(clk), .line_i(txd), .line_o(rline), .got_o(got),
        .got_v_o(got_v));

    // A read notes its expected value and mask; the data-phase watcher compares.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, m);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        dph <= !w;
        if (!w) qe.push_back(d);
        if (!w) qm.push_back(m);
        do @(posedge clk); while (hready !== 1'b1);
        dph <= 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(negedge clk) begin
        logic [31:0] e, m;
        if (dph) begin
            e = qe.pop_front();
            m = qm.pop_front();
            `CHK("hrdata", e, hrdata & m)
        end
    end

    // Synchronous far side: the data line is taken on each rising shift clock.
    always @(posedge txd) begin
        if (rxd_oe) sb <= {rxd_o, sb[7:1]};
    end

    always @(posedge got_v) begin
        if (qt.size() > 0) `CHK("tx frame", qt.pop_front(), got)
    end

    initial begin
        void'($urandom(32'h8C51A0AB));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        bus(0, assc_pkg::A_CTRL, 32'h0, '1);
        bus(0, 5'h18, 32'h0, '1);
        bus(1, assc_pkg::A_BAUD, 32'h0, 32'h0);
        bus(1, assc_pkg::A_MASK, 32'h4, 32'h0);
        bus(1, assc_pkg::A_CTRL, 32'h189, 32'h0);
        b = 8'($urandom());
        qt.push_back(b);
        bus(1, assc_pkg::A_TXDATA, {24'h0, b}, 32'h0);
        for (int i = 0; i < 400 && qt.size() > 0; i++) @(posedge clk);
        `CHK("tx done", 0, qt.size())
        b = 8'($urandom());
        u_rem.send({1'b0, b}, 8, 1'b1);
        `CHK("irq", 1'b1, irq)
        `CHK("irq_req", 4'h4, irq_req)
        bus(0, assc_pkg::A_RXDATA, {24'h0, b}, 32'h1FF);
        u_rem.send({1'b0, b}, 8, 1'b1);
        u_rem.send({1'b0, ~b}, 8, 1'b1);
        bus(0, assc_pkg::A_STAT, 32'h40, 32'h40);
        bus(1, assc_pkg::A_STAT, 32'h7F, 32'h0);
        bus(0, assc_pkg::A_STAT, 32'h0, 32'h7F);
        `CHK("irq", 1'b0, irq)
        `CHK("irq_req", 4'h0, irq_req)
        bus(1, assc_pkg::A_CTRL, 32'h1A3, 32'h0);
        u_rem.send({~(^b), b}, 9, 1'b1);
        bus(0, assc_pkg::A_STAT, 32'h10, 32'h10);
        bus(1, assc_pkg::A_STAT, 32'h7F, 32'h0);
        u_rem.send({^b, b}, 9, 1'b0);
        repeat (40) @(posedge clk);
        bus(0, assc_pkg::A_STAT, 32'h20, 32'h30);
        bus(1, assc_pkg::A_CTRL, 32'h185, 32'h0);
        bus(1, assc_pkg::A_STAT, 32'h7F, 32'h0);
        u_rem.send({1'b0, b}, 9, 1'b1);
        bus(0, assc_pkg::A_STAT, 32'h0, 32'h4);
        u_rem.send({1'b1, b}, 9, 1'b1);
        bus(0, assc_pkg::A_RXDATA, {23'h0, 1'b1, b}, 32'h1FF);
        bus(1, assc_pkg::A_BAUD, 32'h1, 32'h0);
        bus(1, assc_pkg::A_CTRL, 32'h100, 32'h0);
        b = 8'($urandom());
        bus(1, assc_pkg::A_TXDATA, {24'h0, b}, 32'h0);
        repeat (100) @(posedge clk);
        `CHK("sync byte", b, sb)
        `CHK("data oe", 1'b0, rxd_oe)
        bus(1, assc_pkg::A_BAUD, 32'h0, 32'h0);
        bus(1, assc_pkg::A_CTRL, 32'h1C1, 32'h0);
        bus(0, assc_pkg::A_RXDATA, 32'h0, 32'h0);
        bus(1, assc_pkg::A_STAT, 32'h7F, 32'h0);
        b = 8'($urandom());
        bus(1, assc_pkg::A_TXDATA, {24'h0, b}, 32'h0);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
        bus(0, assc_pkg::A_RXDATA, {24'h0, b}, 32'h1FF);
        finish_test();
    end

    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule // test_async_sync_serial_channel

`default_nettype wire
